// ==== inc/divider_resync_pkg.sv ====
package divider_resync_pkg;
    localparam int        AddrWidth       = 4;
    localparam logic [3:0] OffFilterRange = 4'h0;
    localparam logic [3:0] OffDiv0Sync    = 4'h1;
    localparam logic [3:0] OffDiv1Sync    = 4'h2;
    localparam logic [3:0] OffResync      = 4'h3;
    localparam logic [3:0] OffLockStatus  = 4'h4;
    localparam int        RangeMsb        = 3;
    localparam int        HoldBit         = 2;
    localparam int        SoftEnBit       = 1;
    localparam int        LockEnBit       = 0;
    localparam int        ResyncBit       = 0;
    localparam int        LockStatusBit   = 4;
    localparam logic [3:0] RangeBypass    = 4'h0;
    localparam logic [3:0] RangeMax       = 4'hc;
    localparam logic [7:0] FilterReset    = 8'h00;
    localparam logic [7:0] SyncReset      = 8'h00;
    localparam int        LockPulseCycles = 2;
    localparam int        NumDividers     = 2;

    typedef struct packed {
        logic powerupHold;
        logic softEnable;
        logic lockEnable;
    } div_ctrl_t;
endpackage : divider_resync_pkg

// ==== src/divider_reset_gen.sv ====
`timescale 1ns/1ps
// one per divider; runs in the divider's own clock domain
module divider_reset_gen (
    input  wire logic                           divClk,
    input  wire logic                           rst_n,
    input  wire divider_resync_pkg::div_ctrl_t  ctrl,
    input  wire logic                           lockIn,
    input  wire logic                           resyncIn,
    output logic                                divReset_n
);
    logic [1:0] lockSync;
    logic [1:0] resyncSync;
    divider_resync_pkg::div_ctrl_t ctrlMeta;
    divider_resync_pkg::div_ctrl_t ctrlSync;
    logic       lockSeen;
    logic       next_lockSeen;
    logic [1:0] pulseCnt;
    logic [1:0] next_pulseCnt;
    logic       next_divReset_n;
    logic       lockRise;

    // first stage feeds only the second stage
    always_ff @(posedge divClk or negedge rst_n) begin
        if (!rst_n) begin
            lockSync   <= 2'h0;
            resyncSync <= 2'h0;
            ctrlMeta   <= '0;
            ctrlSync   <= '0;
        end else begin
            lockSync   <= {lockSync[0], lockIn};
            resyncSync <= {resyncSync[0], resyncIn};
            // control bits come from the register clock; adds two edges of latency
            ctrlMeta   <= ctrl;
            ctrlSync   <= ctrlMeta;
        end
    end

    assign lockRise = lockSync[1] & ~lockSeen;

    always_comb begin
        next_lockSeen = lockSync[1];
        next_pulseCnt = (pulseCnt != 2'h0) ? pulseCnt - 2'h1 : 2'h0;
        // lock-triggered resync reset, once per acquisition
        if (lockRise && (ctrlSync.lockEnable || ctrlSync.powerupHold)) begin
            next_pulseCnt = 2'(divider_resync_pkg::LockPulseCycles);
        end
        next_divReset_n = 1'b1;
        if (ctrlSync.powerupHold && !lockSync[1]) begin
            next_divReset_n = 1'b0;
        end
        if (next_pulseCnt != 2'h0) begin
            next_divReset_n = 1'b0;
        end
        // reset follows request level; released synchronously on drop
        if (ctrlSync.softEnable && resyncSync[1]) begin
            next_divReset_n = 1'b0;
        end
    end

    always_ff @(posedge divClk or negedge rst_n) begin
        if (!rst_n) begin
            lockSeen   <= 1'b0;
            pulseCnt   <= 2'h0;
            divReset_n <= 1'b1;
        end else begin
            lockSeen   <= next_lockSeen;
            pulseCnt   <= next_pulseCnt;
            divReset_n <= next_divReset_n;
        end
    end
endmodule : divider_reset_gen

// ==== src/divider_resync_control.sv ====
`timescale 1ns/1ps
module divider_resync_control (
    input  wire logic                                   clk,
    input  wire logic                                   rst_n,
    input  wire logic [divider_resync_pkg::AddrWidth-1:0] regAddr,
    input  wire logic [7:0]                             regWdata,
    input  wire logic                                   regWrite,
    input  wire logic                                   regRead,
    output logic      [7:0]                             regRdata,
    input  wire logic                                   pllLock,
    input  wire logic [1:0]                             divClk,
    output logic      [3:0]                             filterRange,
    output logic                                        filterBypass,
    output logic      [1:0]                             divReset_n
);
    logic [7:0] filterReg;
    logic [7:0] next_filterReg;
    divider_resync_pkg::div_ctrl_t divCtrl [2];
    divider_resync_pkg::div_ctrl_t next_divCtrl [2];
    logic       resyncReq;
    logic       next_resyncReq;
    logic [7:0] next_regRdata;
    logic [1:0] lockSync;

    // pll lock comes from the analog side
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            lockSync <= 2'h0;
        end else begin
            lockSync <= {lockSync[0], pllLock};
        end
    end

    function automatic logic [7:0] pack_ctrl(input divider_resync_pkg::div_ctrl_t c);
        pack_ctrl = {5'h00, c};
    endfunction : pack_ctrl

    function automatic divider_resync_pkg::div_ctrl_t unpack_ctrl(input logic [7:0] d);
        unpack_ctrl = d[2:0];
    endfunction : unpack_ctrl

    always_comb begin
        next_filterReg = filterReg;
        next_divCtrl   = divCtrl;
        next_resyncReq = resyncReq;
        if (regWrite) begin
            case (regAddr)
                divider_resync_pkg::OffFilterRange: begin
                    next_filterReg = {4'h0, regWdata[divider_resync_pkg::RangeMsb:0]};
                end
                divider_resync_pkg::OffDiv0Sync: begin
                    next_divCtrl[0] = unpack_ctrl(regWdata);
                end
                divider_resync_pkg::OffDiv1Sync: begin
                    next_divCtrl[1] = unpack_ctrl(regWdata);
                end
                divider_resync_pkg::OffResync: begin
                    next_resyncReq = regWdata[divider_resync_pkg::ResyncBit];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        next_regRdata = 8'h00;
        if (regRead) begin
            case (regAddr)
                divider_resync_pkg::OffFilterRange: next_regRdata = filterReg;
                divider_resync_pkg::OffDiv0Sync:    next_regRdata = pack_ctrl(divCtrl[0]);
                divider_resync_pkg::OffDiv1Sync:    next_regRdata = pack_ctrl(divCtrl[1]);
                divider_resync_pkg::OffResync:      next_regRdata = {7'h00, resyncReq};
                divider_resync_pkg::OffLockStatus: begin
                    next_regRdata[divider_resync_pkg::LockStatusBit] = lockSync[1];
                end
                default: next_regRdata = 8'h00;
            endcase
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            filterReg <= divider_resync_pkg::FilterReset;
            divCtrl[0] <= '0;
            divCtrl[1] <= '0;
            resyncReq <= 1'b0;
            regRdata  <= 8'h00;
        end else begin
            filterReg <= next_filterReg;
            divCtrl   <= next_divCtrl;
            resyncReq <= next_resyncReq;
            regRdata  <= next_regRdata;
        end
    end

    // codes above the top band are undefined; they pass through unchanged
    assign filterRange  = filterReg[3:0];
    assign filterBypass = (filterReg[3:0] == divider_resync_pkg::RangeBypass);

    // controls are quasi-static; software changes them only while dividers idle
    genvar i;
    generate
        for (i = 0; i < divider_resync_pkg::NumDividers; i++) begin : g_div
            divider_reset_gen u_gen (
                .divClk     (divClk[i]),
                .rst_n      (rst_n),
                .ctrl       (divCtrl[i]),
                .lockIn     (pllLock),
                .resyncIn   (resyncReq),
                .divReset_n (divReset_n[i])
            );
        end
    endgenerate
endmodule : divider_resync_control

// ==== verification/divider_resync_control_sva.sv ====
`timescale 1ns/1ps
module divider_resync_control_sva (
    input wire logic       clk,
    input wire logic       rst_n,
    input wire logic [3:0] regAddr,
    input wire logic [7:0] regWdata,
    input wire logic       regWrite,
    input wire logic       regRead,
    input wire logic [7:0] regRdata,
    input wire logic       pllLock,
    input wire logic [1:0] divClk,
    input wire logic [3:0] filterRange,
    input wire logic       filterBypass,
    input wire logic [1:0] divReset_n
);
    logic [2:0] ctl0;
    logic [2:0] ctl1;
    logic       req;
    // shadow of the control registers, since only the ports are visible here
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctl0 <= 3'h0;
            ctl1 <= 3'h0;
            req <= 1'b0;
        end else if (regWrite) begin
            if (regAddr == 4'h1) ctl0 <= regWdata[2:0];
            if (regAddr == 4'h2) ctl1 <= regWdata[2:0];
            if (regAddr == 4'h3) req <= regWdata[0];
        end
    end
    property p_byp; @(posedge clk) disable iff (!rst_n) filterBypass == (filterRange == 4'h0);
    endproperty
    a_byp: assert property (p_byp) else $error("bypass flag");
    property p_rng; @(posedge clk) disable iff (!rst_n)
        regWrite && regAddr == 4'h0 |=> filterRange == $past(regWdata[3:0]); endproperty
    a_rng: assert property (p_rng) else $error("range field");
    property p_resv; @(posedge clk) disable iff (!rst_n)
        regRead && regAddr inside {4'h1, 4'h2} |=> regRdata[7:3] == 5'h00; endproperty
    a_resv: assert property (p_resv) else $error("reserved bits");
    property p_soft; @(posedge divClk[0]) disable iff (!rst_n)
        $rose(req) && ctl0 == 3'h2 |-> ##[1:8] !divReset_n[0]; endproperty
    a_soft: assert property (p_soft) else $error("no soft reset");
    property p_rel; @(posedge divClk[0]) disable iff (!rst_n)
        $fell(req) && ctl0 == 3'h2 |-> ##[1:8] divReset_n[0]; endproperty
    a_rel: assert property (p_rel) else $error("no release");
    property p_quiet; @(posedge divClk[1]) disable iff (!rst_n)
        (ctl1 == 3'h0) [*8] |-> divReset_n[1]; endproperty
    a_quiet: assert property (p_quiet) else $error("reset while disabled");
    property p_hold; @(posedge divClk[1]) disable iff (!rst_n)
        (ctl1[2] && !pllLock) [*8] |-> !divReset_n[1]; endproperty
    a_hold: assert property (p_hold) else $error("hold not kept");
    property p_lock; @(posedge divClk[0]) disable iff (!rst_n)
        $rose(pllLock) && ctl0[0] |-> ##[1:8] !divReset_n[0]; endproperty
    a_lock: assert property (p_lock) else $error("no lock reset");
endmodule : divider_resync_control_sva

// ==== verification/divider_resync_control_tb.sv ====
`timescale 1ns/1ps
`define CK(a, b) begin samples_checked++; if ((a) !== (b)) begin error_cnt++; \
    $display("Error %0t: got %h want %h", $time, a, b); end end
module divider_resync_control_tb;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [3:0]  regAddr = 4'h0;
    logic [7:0]  regWdata = 8'h00;
    logic        regWrite = 1'b0;
    logic        regRead = 1'b0;
    logic        pllLock = 1'b0;
    logic [1:0]  divClk = 2'b00;
    logic [7:0]  regRdata, q;
    logic [3:0]  filterRange;
    logic        filterBypass;
    logic [1:0]  divReset_n;
    int          error_cnt = 0;
    int          samples_checked = 0;
    // address, write data, read-back
    logic [19:0] rows [8] = '{20'h0ff0f, 20'h00c0c, 20'h1ff07, 20'h2f800,
                              20'h55500, 20'h4ff00, 20'h3fe00, 20'h00000};
    always #2 clk = ~clk;
    always #1.5 divClk[0] = ~divClk[0];
    always #1.75 divClk[1] = ~divClk[1];
    divider_resync_control uut (.clk(clk), .rst_n(rst_n), .regAddr(regAddr),
        .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
        .pllLock(pllLock), .divClk(divClk), .filterRange(filterRange),
        .filterBypass(filterBypass), .divReset_n(divReset_n));
    task automatic tally_and_finish();
        $display("errors %0d checks %0d", error_cnt, samples_checked);
        if (error_cnt == 0 && samples_checked > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask : tally_and_finish
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        regAddr <= a;
        regWdata <= d;
        regWrite <= 1'b1;
        @(posedge clk);
        regWrite <= 1'b0;
        @(posedge clk);
    endtask : wr
    task automatic rd(input logic [3:0] a);
        regAddr <= a;
        regRead <= 1'b1;
        @(posedge clk);
        regRead <= 1'b0;
        @(posedge clk);
        q = regRdata;
    endtask : rd
    // bounded wait for the divider resets to settle
    task automatic wt(input logic [1:0] w);
        for (int i = 0; i < 60 && divReset_n !== w; i++) @(posedge clk);
        `CK(divReset_n, w)
        if (divReset_n !== w) tally_and_finish();
    endtask : wt
    initial begin
        repeat (2) @(posedge clk);
        `CK({regRdata, filterRange, filterBypass, divReset_n}, 15'h0007)
        rst_n <= 1'b1;
        @(posedge clk);
        foreach (rows[i]) begin
            wr(rows[i][19:16], rows[i][15:8]);
            rd(rows[i][19:16]);
            `CK(q, rows[i][7:0])
        end
        `CK({filterRange, filterBypass}, 5'h01)
        wr(4'h1, 8'h02);
        wr(4'h3, 8'h01);
        wt(2'b10);
        wr(4'h3, 8'h00);
        wt(2'b11);
        wr(4'h1, 8'h01);
        wr(4'h2, 8'h04);
        wt(2'b01);
        pllLock <= 1'b1;
        wt(2'b11);
        rd(4'h4);
        `CK(q, 8'h10)
        tally_and_finish();
    end
endmodule : divider_resync_control_tb
bind divider_resync_control divider_resync_control_sva chk (.clk(clk), .rst_n(rst_n),
    .regAddr(regAddr), .regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
    .regRdata(regRdata), .pllLock(pllLock), .divClk(divClk), .filterRange(filterRange),
    .filterBypass(filterBypass), .divReset_n(divReset_n));
